// ==== src/smr_defs.svh ====
// timing counts and command codes for the mask rom host controller
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
`define SMR_CLK_PERIOD_NS   25
`define SMR_ACCESS_MAX_NS   7000
`define SMR_ACCESS_CYC      ((`SMR_ACCESS_MAX_NS + `SMR_CLK_PERIOD_NS - 1) / `SMR_CLK_PERIOD_NS)
`define SMR_STROBE_CYC      2
`define SMR_CMD_READ1       8'h00
`define SMR_CMD_READ2       8'h01
`define SMR_CMD_READ3       8'h50
`define SMR_CMD_RESET       8'hff
`define SMR_CMD_STATUS      8'h70
`define SMR_CMD_ID          8'h90
`define SMR_MAIN_BYTES      512
`define SMR_RED_BYTES       16
`define SMR_PAGE_BYTES      528
`define SMR_PAGES_PER_BLK   32
`define SMR_BLOCKS          2048
`define SMR_RED_FILL        8'hff
`endif

// ==== src/smr_pkg.sv ====
// types for the mask rom host controller
package smr_pkg;
    typedef enum logic [2:0]
    {
        SMR_OP_READ1  = 3'h0,
        SMR_OP_READ2  = 3'h1,
        SMR_OP_READ3  = 3'h2,
        SMR_OP_STATUS = 3'h3,
        SMR_OP_ID     = 3'h4,
        SMR_OP_RESET  = 3'h5
    } smr_op_t;

    typedef struct packed
    {
        smr_op_t     op;
        logic [24:0] addr;
        logic [9:0]  count;
    } smr_req_t;

    typedef struct packed
    {
        logic       cle;
        logic       ale;
        logic       ce_n;
        logic       we_n;
        logic       re_n;
        logic [7:0] dq_o;
        logic       dq_oe;
    } smr_pins_t;
endpackage

// ==== src/smr_host.sv ====
// host controller driving the byte-wide mask rom pins
`timescale 1ns/10ps
`include "smr_defs.svh"

// Operation
// - host raises command latch and pulses write strobe to issue a command
// - host raises address latch and pulses write strobe per address byte
// - chip select high puts device in standby, byte lines released
// - commands, addresses and data share the same eight byte lines
// - host issues only the six documented command codes
// - only reset may be issued while the device is busy
// - identification read takes an all-zero first address byte
module smr_host
#(
    parameter int ACCESS_CYC = `SMR_ACCESS_CYC
)
(
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             req_valid_i,
    output logic                  req_ready_o,
    input  wire smr_pkg::smr_req_t req_i,
    output logic                  rd_valid_o,
    output logic [7:0]            rd_data_o,
    output logic                  done_o,
    output logic                  timeout_o,
    output logic                  cle_o,
    output logic                  ale_o,
    output logic                  ce_n_o,
    output logic                  we_n_o,
    output logic                  re_n_o,
    input  wire logic [7:0]       byte_lines_i,
    output logic [7:0]            byte_lines_o,
    output logic                  byte_lines_oe_o,
    input  wire logic             ready_busy_n_i
);
    // ==========================================================
    // ready/busy pin input synchroniser
    logic [2:0] rb_sync_q;
    logic [2:0] rb_sync_d;
    logic       rb_ready_q;
    logic       rb_ready_d;

    always_comb
    begin
        rb_sync_d  = {rb_sync_q[1:0], ready_busy_n_i};
        rb_ready_d = rb_ready_q;
        // a change counts only once the last two stages agree
        if (rb_sync_q[2] == rb_sync_q[1])
        begin
            rb_ready_d = rb_sync_q[2];
        end
    end

    // ==========================================================
    // sequencer
    typedef enum logic [7:0]
    {
        ST_IDLE = 8'h01,
        ST_CMD  = 8'h02,
        ST_ADDR = 8'h04,
        ST_WAIT = 8'h08,
        ST_RLOW = 8'h10,
        ST_RHI  = 8'h20,
        ST_DONE = 8'h40,
        ST_GAP  = 8'h80
    } st_t;

    st_t                 st_q, st_d;
    smr_pkg::smr_req_t   req_q, req_d;
    smr_pkg::smr_pins_t  pin_q, pin_d;
    logic [1:0]          acnt_q, acnt_d;
    logic [1:0]          ph_q, ph_d;
    logic [15:0]         tcnt_q, tcnt_d;
    logic [9:0]          bcnt_q, bcnt_d;
    logic [7:0]          data_q, data_d;
    logic                dv_q, dv_d;
    logic                done_q, done_d;
    logic                to_q, to_d;
    logic                seen_busy_q, seen_busy_d;
    logic [7:0]          cmd_code;
    logic [1:0]          naddr;
    logic                is_read;

    always_comb
    begin
        cmd_code = `SMR_CMD_RESET;
        naddr    = 2'h0;
        is_read  = 1'b0;
        case (req_q.op)
            smr_pkg::SMR_OP_READ1:
            begin
                cmd_code = `SMR_CMD_READ1;
                naddr    = 2'h3;
                is_read  = 1'b1;
            end
            smr_pkg::SMR_OP_READ2:
            begin
                cmd_code = `SMR_CMD_READ2;
                naddr    = 2'h3;
                is_read  = 1'b1;
            end
            smr_pkg::SMR_OP_READ3:
            begin
                cmd_code = `SMR_CMD_READ3;
                naddr    = 2'h3;
                is_read  = 1'b1;
            end
            smr_pkg::SMR_OP_STATUS:
            begin
                cmd_code = `SMR_CMD_STATUS;
            end
            smr_pkg::SMR_OP_ID:
            begin
                cmd_code = `SMR_CMD_ID;
                naddr    = 2'h1;
            end
            default:
            begin
                cmd_code = `SMR_CMD_RESET;
            end
        endcase
    end

    always_comb
    begin
        st_d        = st_q;
        req_d       = req_q;
        pin_d       = pin_q;
        acnt_d      = acnt_q;
        ph_d        = ph_q;
        tcnt_d      = tcnt_q;
        bcnt_d      = bcnt_q;
        data_d      = data_q;
        dv_d        = 1'b0;
        done_d      = 1'b0;
        to_d        = 1'b0;
        seen_busy_d = seen_busy_q;
        case (st_q)
            ST_IDLE:
            begin
                pin_d.ce_n  = 1'b1;
                pin_d.dq_oe = 1'b0;
                // only reset goes out while the device reports busy
                if (req_valid_i && (rb_ready_q ||
                    req_i.op == smr_pkg::SMR_OP_RESET))
                begin
                    req_d = req_i;
                    st_d  = ST_CMD;
                    ph_d  = 2'h0;
                end
            end
            ST_CMD:
            begin
                pin_d.ce_n  = 1'b0;
                pin_d.cle   = 1'b1;
                pin_d.ale   = 1'b0;
                pin_d.dq_o  = cmd_code;
                pin_d.dq_oe = 1'b1;
                ph_d        = ph_q + 2'h1;
                pin_d.we_n  = (ph_q < 2'(`SMR_STROBE_CYC)) ? 1'b0 : 1'b1;
                if (ph_q == 2'h3)
                begin
                    pin_d.cle = 1'b0;
                    ph_d      = 2'h0;
                    acnt_d    = 2'h0;
                    seen_busy_d = 1'b0;
                    tcnt_d    = 16'h0;
                    st_d      = (naddr != 2'h0) ? ST_ADDR : ST_WAIT;
                end
            end
            ST_ADDR:
            begin
                pin_d.ale   = 1'b1;
                pin_d.dq_oe = 1'b1;
                case (acnt_q)
                    2'h0:    pin_d.dq_o = (req_q.op == smr_pkg::SMR_OP_ID) ? 8'h00
                                          : req_q.addr[7:0];
                    2'h1:    pin_d.dq_o = req_q.addr[16:9];
                    default: pin_d.dq_o = req_q.addr[24:17];
                endcase
                ph_d       = ph_q + 2'h1;
                pin_d.we_n = (ph_q < 2'(`SMR_STROBE_CYC)) ? 1'b0 : 1'b1;
                if (ph_q == 2'h3)
                begin
                    ph_d   = 2'h0;
                    acnt_d = acnt_q + 2'h1;
                    if (acnt_q + 2'h1 == naddr)
                    begin
                        pin_d.ale   = 1'b0;
                        pin_d.dq_oe = 1'b0;
                        st_d        = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                pin_d.dq_oe = 1'b0;
                tcnt_d      = tcnt_q + 16'h1;
                if (!rb_ready_q)
                begin
                    seen_busy_d = 1'b1;
                end
                if (req_q.op == smr_pkg::SMR_OP_RESET)
                begin
                    if (rb_ready_q && tcnt_q > 16'h8)
                    begin
                        st_d = ST_DONE;
                    end
                    // a device stuck busy must not hang the sequencer
                    else if (tcnt_q >= 16'(ACCESS_CYC + 16))
                    begin
                        to_d = 1'b1;
                        st_d = ST_DONE;
                    end
                end
                else if (!is_read || (rb_ready_q && seen_busy_q))
                begin
                    bcnt_d = req_q.count;
                    st_d   = (req_q.count == 10'h0) ? ST_DONE : ST_RLOW;
                    ph_d   = 2'h0;
                end
                else if (tcnt_q >= 16'(ACCESS_CYC + 16))
                begin
                    to_d = 1'b1;
                    st_d = ST_DONE;
                end
            end
            ST_RLOW:
            begin
                pin_d.re_n = 1'b0;
                ph_d       = ph_q + 2'h1;
                if (ph_q == 2'h2)
                begin
                    // sample late in the low phase so the device output has settled
                    data_d = byte_lines_i;
                    dv_d   = 1'b1;
                    ph_d   = 2'h0;
                    st_d   = ST_RHI;
                end
            end
            ST_RHI:
            begin
                pin_d.re_n = 1'b1;
                ph_d       = ph_q + 2'h1;
                if (ph_q == 2'h1)
                begin
                    ph_d   = 2'h0;
                    bcnt_d = bcnt_q - 10'h1;
                    st_d   = (bcnt_q == 10'h1) ? ST_DONE : ST_RLOW;
                end
            end
            ST_DONE:
            begin
                pin_d.ce_n = 1'b1;
                pin_d.re_n = 1'b1;
                done_d     = 1'b1;
                to_d       = to_q;
                st_d       = ST_GAP;
            end
            ST_GAP:
            begin
                st_d = ST_IDLE;
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rb_sync_q   <= 3'h7;
            rb_ready_q  <= 1'b1;
            st_q        <= ST_IDLE;
            req_q       <= '0;
            pin_q       <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                             re_n: 1'b1, dq_o: 8'h00, dq_oe: 1'b0};
            acnt_q      <= 2'h0;
            ph_q        <= 2'h0;
            tcnt_q      <= 16'h0;
            bcnt_q      <= 10'h0;
            data_q      <= 8'h00;
            dv_q        <= 1'b0;
            done_q      <= 1'b0;
            to_q        <= 1'b0;
            seen_busy_q <= 1'b0;
        end
        else
        begin
            rb_sync_q   <= rb_sync_d;
            rb_ready_q  <= rb_ready_d;
            st_q        <= st_d;
            req_q       <= req_d;
            pin_q       <= pin_d;
            acnt_q      <= acnt_d;
            ph_q        <= ph_d;
            tcnt_q      <= tcnt_d;
            bcnt_q      <= bcnt_d;
            data_q      <= data_d;
            dv_q        <= dv_d;
            done_q      <= done_d;
            to_q        <= to_d;
            seen_busy_q <= seen_busy_d;
        end
    end

    assign req_ready_o     = (st_q == ST_IDLE) &&
                             (rb_ready_q || req_i.op == smr_pkg::SMR_OP_RESET);
    assign rd_valid_o      = dv_q;
    assign rd_data_o       = data_q;
    assign done_o          = done_q;
    assign timeout_o       = done_q & to_q;
    assign cle_o           = pin_q.cle;
    assign ale_o           = pin_q.ale;
    assign ce_n_o          = pin_q.ce_n;
    assign we_n_o          = pin_q.we_n;
    assign re_n_o          = pin_q.re_n;
    assign byte_lines_o    = pin_q.dq_o;
    assign byte_lines_oe_o = pin_q.dq_oe;
endmodule // smr_host

// ==== testbench/smr_host_monitor.sv ====
// assertion checker for the mask rom host controller pins
`timescale 1ns/10ps
module smr_host_monitor
(
    input wire logic              ref_clk_i,
    input wire logic              resetn_i,
    input wire logic              req_ready_o,
    input wire smr_pkg::smr_req_t req_i,
    input wire logic              ready_busy_n_i,
    input wire logic              rd_valid_o,
    input wire logic              done_o,
    input wire logic              timeout_o,
    input wire logic              cle_o,
    input wire logic              ale_o,
    input wire logic              ce_n_o,
    input wire logic              we_n_o,
    input wire logic              re_n_o,
    input wire logic              byte_lines_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // ====================
    // pin relations
    chk_latch_excl: assert property (!(cle_o && ale_o))
        else $error("both latch strobes high");
    chk_cmd_drive: assert property ($fell(we_n_o) && cle_o |-> byte_lines_oe_o && !ce_n_o)
        else $error("command byte not driven");
    chk_addr_drive: assert property ($fell(we_n_o) && ale_o |-> byte_lines_oe_o && !ce_n_o)
        else $error("address byte not driven");
    chk_we_pulse: assert property ($fell(we_n_o) |=> !we_n_o ##1 we_n_o[*2])
        else $error("write strobe shape wrong");
    chk_re_pulse: assert property ($fell(re_n_o) |=> !re_n_o ##1 !re_n_o ##1 re_n_o[*2])
        else $error("read strobe shape wrong");
    chk_read_cycle: assert property (!re_n_o |-> !byte_lines_oe_o && !cle_o && !ale_o
        && we_n_o && !ce_n_o)
        else $error("read strobe outside serial read");
    chk_busy_refuse: assert property ((!ready_busy_n_i)[*5] ##0
        req_i.op != smr_pkg::SMR_OP_RESET |-> !req_ready_o)
        else $error("request taken while busy");
    chk_standby_idle: assert property (ce_n_o |-> we_n_o && re_n_o && !byte_lines_oe_o)
        else $error("activity while deselected");
    chk_timeout_pair: assert property (timeout_o |-> ce_n_o && re_n_o && !byte_lines_oe_o)
        else $error("timeout without release");
    chk_done_release: assert property (done_o |-> ##[0:2] ce_n_o)
        else $error("chip select not released");
    cover property (rd_valid_o);
    cover property (done_o && timeout_o);
    cover property (req_ready_o && req_i.op == smr_pkg::SMR_OP_RESET);
endmodule // smr_host_monitor

bind smr_host smr_host_monitor smr_host_monitor_inst (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .ready_busy_n_i(ready_busy_n_i), .rd_valid_o(rd_valid_o), .done_o(done_o),
    .timeout_o(timeout_o), .cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
    .re_n_o(re_n_o), .byte_lines_oe_o(byte_lines_oe_o));

// ==== testbench/smr_rom_model.sv ====
// behavioural model of the byte-wide mask rom
`timescale 1ns/10ps
module smr_rom_model
#(
    parameter logic [7:0] ID0 = 8'ha5, // arbitrary
    parameter logic [7:0] ID1 = 8'h3c  // arbitrary
)
(
    input  wire logic        cle_i,
    input  wire logic        ale_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        re_n_i,
    input  wire logic [7:0]  lines_i,
    input  wire logic [15:0] busy_ns_i,
    input  wire logic        no_busy_i,
    output logic [7:0]       lines_o,
    output logic             lines_oe_o,
    output logic             rb_low_o,
    output logic [7:0]       fault_o
);
    logic [7:0] cmd, q, a [3];
    int         na, col, row;
    initial {lines_o, lines_oe_o, rb_low_o, fault_o, cmd, na} = '0;
    // ====================
    // strobe decode
    task automatic go_busy(input int d);
        fork
            begin
                #50 rb_low_o = 1'b1;
                #(d) rb_low_o = 1'b0;
            end
        join_none
    endtask
    always @(posedge we_n_i) if (ce_n_i === 1'b0)
    begin
        if (cle_i && ale_i) fault_o++;
        else if (cle_i)
        begin
            if (rb_low_o && lines_i !== 8'hff) fault_o++;
            cmd = lines_i;
            na = 0;
            if (cmd == 8'hff) go_busy(150);
        end
        else if (ale_i && na < 3)
        begin
            a[na] = lines_i;
            na++;
            if (cmd == 8'h90 && lines_i !== 8'h00) fault_o++;
            col = 0;
            row = {a[2], a[1]};
            if (cmd != 8'h90)
                col = cmd == 8'h50 ? 512 + a[0][3:0] : a[0] + (cmd[0] ? 256 : 0);
            if (na == 3 && cmd != 8'h90 && !no_busy_i) go_busy(busy_ns_i);
        end
    end
    // each page is 512 main bytes then 16 all-ones bytes; columns past 528 also read as all ones
    always @(negedge re_n_i) if (ce_n_i === 1'b0)
    begin
        if (cmd == 8'h70) q = 8'hc0; // arbitrary ready status
        else if (cmd == 8'h90) q = col == 0 ? ID0 : ID1;
        else q = col >= 512 ? 8'hff : col[7:0] ^ row[7:0] ^ {col[8], 7'h0};
        #5 lines_o = q;
        lines_oe_o = 1'b1;
    end
    always @(posedge re_n_i or posedge ce_n_i)
    begin
        lines_oe_o = 1'b0;
        lines_o = ~q; // released lines must not keep the last byte
        if (!ce_n_i) col++;
    end
endmodule // smr_rom_model

// ==== testbench/tb.sv ====
// self-checking testbench for the mask rom host controller
`timescale 1ns/10ps
module tb;
    typedef struct packed {smr_pkg::smr_req_t r; logic [15:0] e;} smr_row_t;
    logic clk, rstn, vld, rb_force, nobusy, rdy, rv, dn, to_o, cle, ale, ce_n, we_n, re_n;
    logic h_oe, d_oe, rb_low, rb, t;
    logic [7:0] rdat, h_o, d_o, bus, faults;
    logic [15:0] busy_ns, got;
    int err_total, compares, cyc, n;
    smr_pkg::smr_req_t req;
    smr_row_t rows [6] = '{
        '{'{smr_pkg::SMR_OP_READ1, 25'h0000610, 10'h2}, 16'h1312},
        '{'{smr_pkg::SMR_OP_READ2, 25'h00006ff, 10'h2}, 16'h7cff},
        '{'{smr_pkg::SMR_OP_READ3, 25'h0000605, 10'h2}, 16'hffff},
        '{'{smr_pkg::SMR_OP_STATUS, 25'h0, 10'h1}, 16'h00c0},
        '{'{smr_pkg::SMR_OP_ID, 25'h0, 10'h2}, 16'ha53c},
        '{'{smr_pkg::SMR_OP_RESET, 25'h0, 10'h0}, 16'h0000}};
    assign bus = h_oe ? h_o : d_o;
    assign rb = !(rb_low || rb_force); // open drain with pull-up
    smr_host #(.ACCESS_CYC(20)) smr_host_inst (.ref_clk_i(clk), .resetn_i(rstn),
        .req_valid_i(vld), .req_ready_o(rdy), .req_i(req), .rd_valid_o(rv), .rd_data_o(rdat),
        .done_o(dn), .timeout_o(to_o), .cle_o(cle), .ale_o(ale), .ce_n_o(ce_n),
        .we_n_o(we_n), .re_n_o(re_n), .byte_lines_i(bus), .byte_lines_o(h_o),
        .byte_lines_oe_o(h_oe), .ready_busy_n_i(rb));
    smr_rom_model smr_rom_model_inst (.cle_i(cle), .ale_i(ale), .ce_n_i(ce_n), .we_n_i(we_n),
        .re_n_i(re_n), .lines_i(bus), .busy_ns_i(busy_ns), .no_busy_i(nobusy),
        .lines_o(d_o), .lines_oe_o(d_oe), .rb_low_o(rb_low), .fault_o(faults));
    // ====================
    // tasks
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) err_total++;
        if (s !== e) $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    endtask
    task automatic end_sim;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(input smr_pkg::smr_req_t r);
        int k;
        {n, got, k} = '0;
        req = r;
        vld = 1'b1;
        while (rdy !== 1'b1 && k++ < 100) @(posedge clk) #2;
        @(posedge clk) #2 vld = 1'b0;
        for (k = 0; k < 3000 && dn !== 1'b1; k++)
        begin
            @(posedge clk) #1;
            n += (rv === 1'b1);
            if (rv === 1'b1) got = {got[7:0], rdat};
        end
        t = to_o;
    endtask
    // ====================
    // stimulus
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000) err_total++;
        if (cyc == 20000) end_sim();
    end
    initial
    begin
        {rstn, vld, rb_force, nobusy, err_total, compares, cyc} = '0;
        req = '0;
        busy_ns = 16'd150;
        repeat (2) @(posedge clk) #2;
        check({ce_n, we_n, re_n, cle, ale, h_oe}, 6'b111000);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            run(rows[i].r);
            check(n, rows[i].r.count);
            check(got, rows[i].e);
            check(t, 1'b0);
            $display("row %0d finished", i);
        end
        busy_ns = 16'd500; // slow device
        run(rows[0].r);
        check(got, 16'h1312);
        nobusy = 1'b1; // device that never goes busy
        run(rows[0].r);
        check(t, 1'b1);
        nobusy = 1'b0;
        $display("slow and silent device finished");
        rb_force = 1'b1;
        repeat (6) @(posedge clk) #2;
        req = rows[0].r;
        #1 check(rdy, 1'b0);
        req = rows[5].r;
        #1 check(rdy, 1'b1);
        rb_force = 1'b0;
        run(rows[5].r);
        check(t, 1'b0);
        $display("busy refusal finished");
        req = rows[2].r;
        vld = 1'b1;
        repeat (10) @(posedge clk) #2;
        {rstn, vld} = '0;
        #1 check({ce_n, we_n, re_n, cle, ale, h_oe}, 6'b111000);
        repeat (2) @(posedge clk) #2;
        rstn = 1'b1;
        run(rows[2].r);
        check(got, 16'hffff);
        check(faults, 8'h00);
        $display("mid-run reset finished");
        end_sim();
    end
endmodule // tb
